//--- hdl/lia_irq_aggregator.sv
// Interrupt latch, mask and summary logic for all line channels.
`timescale 1ns/1ps
`default_nettype none
module lia_irq_aggregator
    import lia_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = lia_pkg::LIA_SEC_CYCLES
)(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_b_i,
    // Level state, per channel
    input  wire lia_pkg::lia_byte_t [lia_pkg::LIA_NCH-1:0] status_zero_i,
    input  wire lia_pkg::lia_byte_t [lia_pkg::LIA_NCH-1:0] status_one_i,
    input  wire lia_pkg::lia_byte_t [lia_pkg::LIA_NCH-1:0] edge_select_i,
    // Event pulses and write-one acks
    input  wire lia_pkg::lia_src_t [lia_pkg::LIA_NCH-1:0] event_i,
    input  wire lia_pkg::lia_src_t [lia_pkg::LIA_NCH-1:0] ack_i,
    // Mask loads and channel resets
    input  wire logic [lia_pkg::LIA_NCH-1:0]              mask_load_i,
    input  wire lia_pkg::lia_src_t [lia_pkg::LIA_NCH-1:0] mask_data_i,
    input  wire logic [lia_pkg::LIA_NCH-1:0]              ch_rst_i,
    // Global config and timer ack
    input  wire logic              cfg_load_i,
    input  wire lia_pkg::lia_byte_t cfg_data_i,
    input  wire logic              tick_ack_i,
    // Status back to software
    output var lia_pkg::lia_src_t [lia_pkg::LIA_NCH-1:0] irq_status_o,
    output var lia_pkg::lia_src_t [lia_pkg::LIA_NCH-1:0] irq_mask_o,
    output var logic [lia_pkg::LIA_NCH-1:0]              channel_summary_o,
    output var logic               second_tick_flag_o,
    output var lia_pkg::lia_byte_t global_config_o,
    // Open-drain interrupt pin
    output var logic               irq_n_o,
    output var logic               irq_oe_o
);
    import lia_pkg::*;

    lia_tick_if tick_if ();

    logic [LIA_NCH-1:0] new_irq;
    logic [LIA_NCH-1:0] pend;
    logic               global_irq_mask;
    logic               tick_pend;
    logic               irq_d;
    lia_src_t           prev_q [LIA_NCH];

    assign global_irq_mask = global_config_o[LIA_GLOBAL_IRQ_MASK_BIT];

    // Second tick source
    lia_sec_timer #(
        .SEC_CYCLES (SEC_CYCLES)
    ) u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_b_i   (rst_b_i),
        .tick_if   (tick_if.src)
    );

    genvar ch;
    genvar b;
    generate
        for (ch = 0; ch < LIA_NCH; ch++)
        begin : g_ch
            lia_src_t lvl;
            lia_src_t es_sel;
            lia_src_t rise;
            lia_src_t fall;
            lia_src_t set_v;

            // Level sources only occupy lanes zero and one
            assign lvl = {8'h00, status_one_i[ch], status_zero_i[ch]};

            // Shared edge select bits fanned out per flag bit
            for (b = 0; b < LIA_SRC_W; b++)
            begin : g_es
                assign es_sel[b] = edge_select_i[ch][lia_es_index(b)];
            end

            assign rise = lvl & ~prev_q[ch];
            assign fall = ~lvl & prev_q[ch];

            // Rising always counts; falling only with edge select
            assign set_v = (LIA_LEVEL_SRC & (rise | (fall & es_sel)))
                         | (LIA_PULSE_SRC & event_i[ch]);

            // Unmasked fresh event in this channel
            assign new_irq[ch] = (|(set_v & ~irq_mask_o[ch])) & ~global_irq_mask;

            // Unmasked flag still waiting for an ack
            assign pend[ch] = |(irq_status_o[ch] & ~irq_mask_o[ch]);

            // Previous level for edge detection
            always_ff @(posedge clk_sys_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    prev_q[ch] <= '0;
                else
                    prev_q[ch] <= lvl & LIA_LEVEL_SRC;
            end

            // Latched flags; a set in the ack cycle wins
            always_ff @(posedge clk_sys_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    irq_status_o[ch] <= '0;
                else if (ch_rst_i[ch])
                    irq_status_o[ch] <= '0;
                else
                    irq_status_o[ch] <= (irq_status_o[ch] & ~ack_i[ch])
                                      | set_v;
            end

            // Masks come up fully masked after any reset
            always_ff @(posedge clk_sys_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    irq_mask_o[ch] <= LIA_MASK_RST;
                else if (ch_rst_i[ch])
                    irq_mask_o[ch] <= LIA_MASK_RST;
                else if (mask_load_i[ch])
                    irq_mask_o[ch] <= mask_data_i[ch] & LIA_MASK_RST;
            end

            // Summary clears a cycle after the last flag goes,
            // so an ack and the clear never race
            always_ff @(posedge clk_sys_i or negedge rst_b_i)
            begin
                if (!rst_b_i)
                    channel_summary_o[ch] <= 1'b0;
                else if (ch_rst_i[ch])
                    channel_summary_o[ch] <= 1'b0;
                else if (new_irq[ch])
                    channel_summary_o[ch] <= 1'b1;
                else if (irq_status_o[ch] == '0)
                    channel_summary_o[ch] <= 1'b0;
            end

            // Direct event lands at its own flag bit
            rx_jbuf_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (event_i[ch][LIA_ST0_LSB + LIA_RX_JBUF_BIT] && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST0_LSB + LIA_RX_JBUF_BIT])
                else $error("rx jitter buffer flag not latched");

            tx_jbuf_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (event_i[ch][LIA_ST0_LSB + LIA_TX_JBUF_BIT] && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST0_LSB + LIA_TX_JBUF_BIT])
                else $error("tx jitter buffer flag not latched");

            amp_ovf_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (event_i[ch][LIA_ST0_LSB + LIA_AMP_OVF_BIT] && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST0_LSB + LIA_AMP_OVF_BIT])
                else $error("amplitude overflow flag not latched");

            pat_err_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (event_i[ch][LIA_ST2_LSB + LIA_PAT_ERR_BIT] && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST2_LSB + LIA_PAT_ERR_BIT])
                else $error("pattern error flag not latched");

            cnt_ovf_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (event_i[ch][LIA_ST2_LSB + LIA_CNT_OVF_BIT] && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST2_LSB + LIA_CNT_OVF_BIT])
                else $error("counter overflow flag not latched");

            // Loop up code: rise always latches
            loop_up_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (status_one_i[ch][LIA_LOOP_UP_BIT]
                 && !prev_q[ch][LIA_ST1_LSB + LIA_LOOP_UP_BIT]
                 && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST1_LSB + LIA_LOOP_UP_BIT])
                else $error("loop up code rise not latched");

            // Pattern sync fall latches only with any-edge select
            psync_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (!status_one_i[ch][LIA_PSYNC_BIT]
                 && prev_q[ch][LIA_ST1_LSB + LIA_PSYNC_BIT]
                 && !irq_status_o[ch][LIA_ST1_LSB + LIA_PSYNC_BIT]
                 && !ack_i[ch][LIA_ST1_LSB + LIA_PSYNC_BIT]
                 && !ch_rst_i[ch])
                |=> (irq_status_o[ch][LIA_ST1_LSB + LIA_PSYNC_BIT]
                     == $past(edge_select_i[ch][LIA_PSYNC_BIT])))
                else $error("pattern sync edge select ignored");

            // Ack without a new set clears the bit
            ack_clear_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (ack_i[ch][LIA_ST2_LSB + LIA_CNT_OVF_BIT]
                 && !event_i[ch][LIA_ST2_LSB + LIA_CNT_OVF_BIT])
                |=> !irq_status_o[ch][LIA_ST2_LSB + LIA_CNT_OVF_BIT])
                else $error("ack did not clear flag");

            // Summary holds while any flag of the channel stands
            summary_hold_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (channel_summary_o[ch] && irq_status_o[ch] != '0
                 && !ch_rst_i[ch])
                |=> channel_summary_o[ch])
                else $error("summary dropped with flags pending");

            summary_set_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (new_irq[ch] && !ch_rst_i[ch]) |=> channel_summary_o[ch])
                else $error("summary not set on unmasked event");

            mask_reset_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                ch_rst_i[ch] |=> (irq_mask_o[ch] == LIA_MASK_RST
                                  && irq_status_o[ch] == '0))
                else $error("channel reset left sources unmasked");

            // A channel with nothing unmasked never raises its summary
            summary_quiet_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (!channel_summary_o[ch] && !new_irq[ch])
                |=> !channel_summary_o[ch])
                else $error("summary set without unmasked event");

            // Last flag gone, the summary drops one cycle later
            summary_clear_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (irq_status_o[ch] == '0 && !new_irq[ch])
                |=> !channel_summary_o[ch])
                else $error("summary stuck after last ack");

            // Line loss level: a rise latches under either select
            los_rise_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (lvl[LIA_ST0_LSB] && !prev_q[ch][LIA_ST0_LSB]
                 && !ch_rst_i[ch])
                |=> irq_status_o[ch][LIA_ST0_LSB])
                else $error("level rise not latched");

            // Line loss fall latches only under any-edge select
            los_fall_a: assert property (
                @(posedge clk_sys_i) disable iff (!rst_b_i)
                (!lvl[LIA_ST0_LSB] && prev_q[ch][LIA_ST0_LSB]
                 && !irq_status_o[ch][LIA_ST0_LSB]
                 && !ack_i[ch][LIA_ST0_LSB] && !ch_rst_i[ch])
                |=> (irq_status_o[ch][LIA_ST0_LSB]
                     == $past(edge_select_i[ch][lia_es_index(LIA_ST0_LSB)])))
                else $error("level fall ignored its edge select");
        end
    endgenerate

    // Global configuration, masked from reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            global_config_o <= LIA_GCFG_RST;
        else if (cfg_load_i)
            global_config_o <= cfg_data_i;
    end

    // Timer flag; the tick wins over a same-cycle ack
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            second_tick_flag_o <= 1'b0;
        else if (tick_if.tick)
            second_tick_flag_o <= 1'b1;
        else if (tick_ack_i)
            second_tick_flag_o <= 1'b0;
    end

    assign tick_pend = second_tick_flag_o
                     & ~global_config_o[LIA_TICK_IM_BIT];

    // Pin follows the pending set, so a late mask also releases it
    assign irq_d = (|pend | tick_pend) & ~global_irq_mask;

    // Pin data is always low; the enable does the pulling
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            irq_n_o  <= 1'b0;
            irq_oe_o <= 1'b0;
        end
        else
        begin
            irq_n_o  <= 1'b0;
            irq_oe_o <= irq_d;
        end
    end

    // Pending unmasked flag pulls the pin next cycle
    irq_assert_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ((|pend || tick_pend) && !global_irq_mask) |=> (irq_oe_o && !irq_n_o))
        else $error("pin not pulled for pending interrupt");

    // With everything acknowledged the pin lets go
    irq_release_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (pend == '0 && !second_tick_flag_o) |=> !irq_oe_o)
        else $error("pin held with nothing pending");

    glb_mask_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        $past(global_config_o[LIA_GLOBAL_IRQ_MASK_BIT]) |-> !irq_oe_o)
        else $error("pin pulled under global mask");

    tick_latch_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        tick_if.tick |=> second_tick_flag_o ##1
        (second_tick_flag_o || $past(tick_ack_i)))
        else $error("timer flag lost");

    // An ack with no tick in the same cycle drops the timer flag
    tick_ack_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (tick_ack_i && !tick_if.tick) |=> !second_tick_flag_o)
        else $error("timer flag survived its ack");

    // Timer flag alone pulls the pin when neither mask is set
    tick_pin_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (second_tick_flag_o && !global_config_o[LIA_TICK_IM_BIT]
         && !global_irq_mask) |=> irq_oe_o)
        else $error("unmasked timer flag did not pull the pin");

    // Main scenarios
    irq_seen_c: cover property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        !irq_oe_o ##1 irq_oe_o ##[1:20] !irq_oe_o);

    summary_c: cover property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        channel_summary_o[0] ##[1:20] !channel_summary_o[0]);

    tick_c: cover property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        second_tick_flag_o && tick_ack_i);

    set_ack_race_c: cover property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (event_i[0] & ack_i[0] & LIA_PULSE_SRC) != '0);

    ch_reset_c: cover property (
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (ch_rst_i & channel_summary_o) != '0);
endmodule
`default_nettype wire

//--- hdl/lia_pkg.sv
// Constants and types shared by the line interrupt aggregator.
`default_nettype none
package lia_pkg;
    localparam int LIA_NCH = 16;
    localparam int LIA_SRC_W = 24;
    typedef logic [LIA_SRC_W-1:0] lia_src_t;
    typedef logic [7:0] lia_byte_t;

    // Byte lanes of the per-channel flag word
    localparam int LIA_ST0_LSB = 0;
    localparam int LIA_ST1_LSB = 8;
    localparam int LIA_ST2_LSB = 16;
    // Direct event and level source bits inside their lanes
    localparam int LIA_RX_JBUF_BIT = 5;
    localparam int LIA_TX_JBUF_BIT = 6;
    localparam int LIA_AMP_OVF_BIT = 7;
    localparam int LIA_PAT_ERR_BIT = 1;
    localparam int LIA_CNT_OVF_BIT = 0;
    localparam int LIA_LOOP_DN_BIT = 0;
    localparam int LIA_LOOP_UP_BIT = 1;
    localparam int LIA_PSYNC_BIT = 5;

    // Which bits come from levels and which from pulses
    localparam lia_src_t LIA_LEVEL_SRC = 24'h00E31F;
    localparam lia_src_t LIA_PULSE_SRC = 24'h3F00E0;
    localparam lia_src_t LIA_MASK_RST = 24'h3FE3FF;

    // Global config layout
    localparam int LIA_TICK_IM_BIT = 0;
    localparam int LIA_GLOBAL_IRQ_MASK_BIT = 1;
    localparam lia_byte_t LIA_GCFG_RST = 8'h03;

    // One-second timer
    localparam int LIA_CLK_NS = 5;
    localparam int LIA_SEC_NS = 1_000_000_000;
    localparam int LIA_SEC_CYCLES = LIA_SEC_NS / LIA_CLK_NS;
    localparam int LIA_TMR_W = 28;

    // Edge select bit that governs a level source bit
    function automatic int lia_es_index(input int idx);
        case (idx)
            0, 1: lia_es_index = 1;
            2: lia_es_index = 2;
            3: lia_es_index = 3;
            4: lia_es_index = 4;
            8, 9: lia_es_index = 0;
            13: lia_es_index = 5;
            default: lia_es_index = 6;
        endcase
    endfunction
endpackage
`default_nettype wire

//--- hdl/lia_tick_if.sv
// Tick carrier between the second timer and the aggregator.
`timescale 1ns/1ps
`default_nettype none
interface lia_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire

//--- hdl/lia_sec_timer.sv
// One-second tick generator on the device clock.
`timescale 1ns/1ps
`default_nettype none
module lia_sec_timer
    import lia_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = lia_pkg::LIA_SEC_CYCLES
)(
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    lia_tick_if.src   tick_if
);
    import lia_pkg::*;

    localparam logic [LIA_TMR_W-1:0] RELOAD = LIA_TMR_W'(SEC_CYCLES - 1);

    logic [LIA_TMR_W-1:0] cnt_q;
    logic                 tick_q;

    // Down counter, one-cycle tick at each expiry
    always_ff @(posedge clk_sys_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end
        else if (cnt_q == '0)
        begin
            cnt_q  <= RELOAD;
            tick_q <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q - 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tick_if.tick = tick_q;

    tick_single_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
        tick_q |-> (cnt_q == RELOAD) ##1 !tick_q)
        else $error("second tick not a single pulse");
endmodule
`default_nettype wire

//--- bench/lia_host_model.sv
// Host side of the open-drain interrupt line, with the board pull-up.
`timescale 1ns/1ps
`default_nettype none
module lia_host_model (
    input  wire logic irq_n_i,
    input  wire logic irq_oe_i,
    output var logic  irq_line_n_o
);
    // Line floats to the pull-up level whenever nobody pulls it down
    always_comb
    begin
        irq_line_n_o = irq_oe_i ? irq_n_i : 1'b1;
    end
endmodule
`default_nettype wire

//--- bench/tb_line_unit_interrupt_aggregator.sv
// Self-checking bench for the line interrupt aggregator.
`timescale 1ns/1ps
`default_nettype none
module tb_line_unit_interrupt_aggregator;
    import lia_pkg::*;
    localparam int       SEC = 50;
    localparam int       CH = 3;
    localparam lia_src_t CNT_B = 24'h000001 << (LIA_ST2_LSB + LIA_CNT_OVF_BIT);
    localparam lia_src_t PAT_B = 24'h000001 << (LIA_ST2_LSB + LIA_PAT_ERR_BIT);
    localparam lia_src_t OTH_B = 24'h200000;

    logic                   clk_sys_i = 1'b0;
    logic                   rst_b_i = 1'b0;
    lia_byte_t [LIA_NCH-1:0] st0 = '0;
    lia_byte_t [LIA_NCH-1:0] st1 = '0;
    lia_byte_t [LIA_NCH-1:0] es = '0;
    lia_src_t [LIA_NCH-1:0] ev = '0;
    lia_src_t [LIA_NCH-1:0] ack = '0;
    lia_src_t [LIA_NCH-1:0] mdat = '0;
    lia_src_t [LIA_NCH-1:0] sts;
    lia_src_t [LIA_NCH-1:0] msk;
    logic [LIA_NCH-1:0]     mld = '0;
    logic [LIA_NCH-1:0]     crst = '0;
    logic [LIA_NCH-1:0]     summ;
    logic                   cld = 1'b0;
    logic                   tack = 1'b0;
    lia_byte_t              cdat = '0;
    lia_byte_t              gcfg;
    logic                   tflag;
    logic                   irq_n;
    logic                   irq_oe;
    logic                   line_n;
    int                     fails = 0;
    int                     samples_checked = 0;

    lia_irq_aggregator #(.SEC_CYCLES(SEC)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .status_zero_i(st0), .status_one_i(st1), .edge_select_i(es),
        .event_i(ev), .ack_i(ack), .mask_load_i(mld), .mask_data_i(mdat),
        .ch_rst_i(crst), .cfg_load_i(cld), .cfg_data_i(cdat),
        .tick_ack_i(tack), .irq_status_o(sts), .irq_mask_o(msk),
        .channel_summary_o(summ), .second_tick_flag_o(tflag),
        .global_config_o(gcfg), .irq_n_o(irq_n), .irq_oe_o(irq_oe)
    );

    lia_host_model host (
        .irq_n_i(irq_n), .irq_oe_i(irq_oe), .irq_line_n_o(line_n)
    );

    // 200 MHz device clock
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Compare helpers, X never matches
    task automatic chk_word(input lia_src_t got, input lia_src_t exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Settle just after an edge so registered outputs have landed
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask

    // One-cycle strobes; each returns just after the capturing edge
    task automatic fire(input lia_src_t v);
        @(posedge clk_sys_i);
        ev[CH] <= v;
        @(posedge clk_sys_i);
        ev[CH] <= '0;
        #1;
    endtask

    task automatic clear(input lia_src_t v);
        @(posedge clk_sys_i);
        ack[CH] <= v;
        @(posedge clk_sys_i);
        ack[CH] <= '0;
        #1;
    endtask

    task automatic set_mask(input lia_src_t v);
        @(posedge clk_sys_i);
        mld[CH] <= 1'b1;
        mdat[CH] <= v;
        @(posedge clk_sys_i);
        mld[CH] <= 1'b0;
        #1;
    endtask

    task automatic set_cfg(input lia_byte_t v);
        @(posedge clk_sys_i);
        cld <= 1'b1;
        cdat <= v;
        @(posedge clk_sys_i);
        cld <= 1'b0;
        #1;
    endtask

    task automatic set_lvl(input lia_byte_t v0, input lia_byte_t v1);
        @(posedge clk_sys_i);
        st0[CH] <= v0;
        st1[CH] <= v1;
        step(2);
    endtask

    // Reset leaves everything masked and idle
    task automatic t_reset();
        chk_word(msk[0], 24'h3FE3FF);
        chk_word(msk[LIA_NCH-1], 24'h3FE3FF);
        chk_word({16'h0000, gcfg}, 24'h000003);
        chk_word(sts[CH], 24'h000000);
        chk_bit(line_n, 1'b1);
        set_mask(24'hFFFFFF);
        chk_word(msk[CH], 24'h3FE3FF);
    endtask

    // Two pending flags: summary and pin hold until the last ack
    task automatic t_two_flags();
        fire(CNT_B | PAT_B);
        chk_word(sts[CH], CNT_B | PAT_B);
        chk_bit(summ[CH], 1'b1);
        step(1);
        chk_bit(line_n, 1'b0);
        clear(CNT_B);
        chk_word(sts[CH], PAT_B);
        step(1);
        chk_bit(summ[CH], 1'b1);
        chk_bit(line_n, 1'b0);
        clear(PAT_B);
        step(1);
        chk_bit(summ[CH], 1'b0);
        chk_bit(line_n, 1'b1);
    endtask

    // Individual and global masks latch but stay silent
    task automatic t_masks();
        int       bl[3];
        lia_src_t v;
        bl = '{LIA_RX_JBUF_BIT, LIA_TX_JBUF_BIT, LIA_AMP_OVF_BIT};
        for (int i = 0; i < 3; i++)
        begin
            v = 24'h000001 << (LIA_ST0_LSB + bl[i]);
            set_mask(v);
            fire(v);
            chk_word(sts[CH], v);
            step(1);
            chk_bit(summ[CH], 1'b0);
            chk_bit(line_n, 1'b1);
            clear(v);
            set_mask(24'h000000);
        end
        set_cfg(8'h03);
        fire(OTH_B);
        step(1);
        chk_bit(summ[CH], 1'b0);
        chk_bit(line_n, 1'b1);
        clear(OTH_B);
        set_cfg(8'h01);
    endtask

    // Rising-only versus any-edge on line loss, loop codes, pattern sync
    task automatic t_edges();
        for (int e = 0; e < 2; e++)
        begin
            @(posedge clk_sys_i);
            es[CH] <= (e == 1) ? 8'h23 : 8'h00;
            set_lvl(8'h01, 8'h23);
            chk_word(sts[CH], 24'h002301);
            clear(24'h002301);
            set_lvl(8'h00, 8'h00);
            chk_word(sts[CH], (e == 1) ? 24'h002301 : 24'h000000);
            clear(24'h002301);
            step(1);
            chk_bit(line_n, 1'b1);
        end
    endtask

    // Second tick recurs after an ack and drives the pin when unmasked
    task automatic t_timer();
        bit seen;
        set_cfg(8'h00);
        @(posedge clk_sys_i);
        tack <= 1'b1;
        @(posedge clk_sys_i);
        tack <= 1'b0;
        #1;
        chk_bit(tflag, 1'b0);
        seen = 1'b0;
        for (int i = 0; i < SEC + 5 && !seen; i++)
        begin
            step(1);
            seen = (tflag === 1'b1);
        end
        if (!seen)
            fails++;
        chk_bit(tflag, 1'b1);
        step(1);
        chk_bit(line_n, 1'b0);
        set_cfg(8'h01);
        step(1);
        chk_bit(line_n, 1'b1);
    endtask

    // Channel reset clears flags and re-masks the channel
    task automatic t_ch_reset();
        fire(OTH_B);
        @(posedge clk_sys_i);
        crst[CH] <= 1'b1;
        @(posedge clk_sys_i);
        crst[CH] <= 1'b0;
        step(1);
        chk_word(sts[CH], 24'h000000);
        chk_word(msk[CH], 24'h3FE3FF);
        chk_bit(summ[CH], 1'b0);
        chk_bit(line_n, 1'b1);
    endtask

    // Main sequence
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        step(1);
        t_reset();
        set_mask(24'h000000);
        set_cfg(8'h01);
        t_two_flags();
        t_masks();
        t_edges();
        t_timer();
        t_ch_reset();
        end_sim();
    end
endmodule
`default_nettype wire
